// ===== dbsp_defines.vh
// Purpose: Shared constants for the DDR burst-of-four SRAM port controller
// Assumes: Controller clock of 10 MHz drives a device clock eight times slower
// Notes:   Timing counts derive from the periods below; change only the periods
`ifndef DBSP_DEFINES_VH
`define DBSP_DEFINES_VH

`define DBSP_CLK_PERIOD_NS   100
`define DBSP_K_PERIOD_NS     800
`define DBSP_K_PHASES        (`DBSP_K_PERIOD_NS / `DBSP_CLK_PERIOD_NS)

`define DBSP_ADDR_W          21
`define DBSP_WORD_W          36
`define DBSP_LANES           4
`define DBSP_BURST           4
`define DBSP_BURST_W         (`DBSP_WORD_W * `DBSP_BURST)
`define DBSP_MASK_W          (`DBSP_LANES * `DBSP_BURST)

// Device clock cycles that must pass after an accepted load before the next one
`define DBSP_BURST_GAP       3'h1
// Idle cycles placed between a read burst and a following write
`define DBSP_RD_WR_IDLE      3'h2
`define DBSP_GAP_SAT         3'h7

// Read latency in device half cycles, with the device PLL on or off
`define DBSP_LAT_HALVES_PLL  3'h3
`define DBSP_LAT_HALVES_DLL  3'h2

// Reset values of the pin outputs
`define DBSP_RST_LOAD_N      1'b1
`define DBSP_RST_MASK_N      4'hf
`define DBSP_RST_PLL_OFF_N   1'b1

`endif

// ===== dbsp_sync.v
// Purpose: Two-stage synchroniser for a bus of pin inputs
// Assumes: Each bit is sampled independently; multi-bit words must be stable
// Notes:   The first stage feeds only the second stage
`default_nettype none

module dbsp_sync #(
	parameter W = 1
) (
	input  wire         i_clk,   // Controller clock
	input  wire         i_nrst,  // Asynchronous reset, active low
	input  wire [W-1:0] i_async, // Pin level from outside the clock domain
	output reg  [W-1:0] o_sync   // Level after two flip-flops
);

	reg [W-1:0] meta_q;

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule // dbsp_sync

`default_nettype wire

// ===== dbsp_ctrl.v
// Purpose: Memory-controller end of a DDR SRAM port with four-word bursts
// Assumes: Device runs in single-clock mode; its clock pair is made here from i_clk
// Notes:   One request per two device cycles; words of a burst travel in burst order
`include "dbsp_defines.vh"
`default_nettype none

module dbsp_ctrl (
	input  wire                      i_clk,              // Controller clock, 10 MHz
	input  wire                      i_nrst,             // Asynchronous reset, active low
	input  wire                      i_pll_on,           // Request device PLL on, static
	input  wire                      i_req_valid,        // Access request present
	input  wire                      i_req_write,        // 1 write, 0 read
	input  wire [`DBSP_ADDR_W-1:0]   i_req_addr,         // Start word address
	input  wire [`DBSP_BURST_W-1:0]  i_wr_data,          // Four write words, word 0 low
	input  wire [`DBSP_MASK_W-1:0]   i_wr_be,            // Byte enables, four per word
	input  wire [`DBSP_WORD_W-1:0]   i_dq,               // Data pins, read direction
	output wire                      o_req_ready,        // Request can be taken this cycle
	output reg                       o_rd_valid,         // Read burst complete, pulse
	output reg  [`DBSP_BURST_W-1:0]  o_rd_data,          // Read burst, word 0 low
	output reg                       o_k,                // Positive input clock
	output wire                      o_k_n,              // Negative input clock
	output wire                      o_c,                // Output clock, strapped high
	output wire                      o_c_n,              // Negative output clock, high
	output reg                       o_load_strobe_n,    // Load strobe, active low
	output reg                       o_access_read,      // Access type, high read
	output reg  [`DBSP_ADDR_W-1:0]   o_addr,             // Address pins
	output reg  [`DBSP_WORD_W-1:0]   o_dq,               // Data pins, write direction
	output reg                       o_dq_oe,            // High while driving data pins
	output reg  [`DBSP_LANES-1:0]    o_byte_lane_mask_n, // Byte-lane masks, active low
	output reg                       o_pll_off_n         // PLL strap, low turns PLL off
);

	// Phase arithmetic is done in integers, then cut to the counter's width
	localparam integer PH_LAST_I = `DBSP_K_PHASES - 1;
	localparam integer PH_HALF_I = `DBSP_K_PHASES / 2;
	localparam integer PH_ACC_I  = `DBSP_K_PHASES - 3;
	localparam [2:0]   PH_LAST   = PH_LAST_I[2:0];
	localparam [2:0]   PH_HALF   = PH_HALF_I[2:0];
	localparam [2:0]   PH_ACC    = PH_ACC_I[2:0];
	localparam [2:0] PH_MID  = PH_ACC - PH_HALF;
	localparam       SLOTS   = `DBSP_BURST + 1;

	reg  [2:0]              phase_q;
	reg  [2:0]              gap_q;
	reg                     last_rd_q;
	reg  [7:0]              rd_sched_q;
	reg  [1:0]              rd_idx_q;
	reg  [`DBSP_WORD_W-1:0] wq_dat [0:SLOTS-1];
	reg  [`DBSP_LANES-1:0]  wq_msk [0:SLOTS-1];
	reg  [SLOTS-1:0]        wq_v;
	wire [`DBSP_WORD_W-1:0] dq_sync;
	wire                    acc_slot;
	wire                    mid_slot;
	wire                    cap_slot;
	wire                    accept;
	wire                    rd_wr_hold;
	wire [2:0]              lat;
	integer                 i;

	dbsp_sync #(
		.W(`DBSP_WORD_W)
	) u_dq_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_async (i_dq),
		.o_sync  (dq_sync)
	);

	// Controls change two controller cycles before the positive clock rise,
	// giving setup and hold margins of two and six cycles around it
	assign acc_slot = (phase_q == PH_ACC);
	assign mid_slot = (phase_q == PH_ACC) || (phase_q == PH_MID);
	// Sampling synchronised data here reads the pins mid-word
	assign cap_slot = (phase_q == PH_LAST) || (phase_q == PH_HALF - 3'h1);

	assign rd_wr_hold  = last_rd_q && i_req_write &&
		(gap_q < `DBSP_BURST_GAP + `DBSP_RD_WR_IDLE);
	assign o_req_ready = acc_slot && (gap_q >= `DBSP_BURST_GAP) &&
		!rd_wr_hold;
	assign accept      = i_req_valid && o_req_ready;

	assign lat   = o_pll_off_n ? `DBSP_LAT_HALVES_PLL : `DBSP_LAT_HALVES_DLL;
	assign o_k_n = ~o_k;
	// Both output clocks held high select single-clock mode; never released
	assign o_c   = 1'b1;
	assign o_c_n = 1'b1;

	// Device clock pair and the phase within one device cycle
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_q     <= 3'h0;
			o_k         <= 1'b0;
			o_pll_off_n <= `DBSP_RST_PLL_OFF_N;
		end else begin
			phase_q     <= (phase_q == PH_LAST) ? 3'h0 : phase_q + 3'h1;
			o_pll_off_n <= i_pll_on;
			if (phase_q == PH_LAST)
				o_k <= 1'b1;
			else if (phase_q == PH_HALF - 3'h1)
				o_k <= 1'b0;
		end
	end

	// Address and control pins, and occupancy of the last accepted burst
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_load_strobe_n <= `DBSP_RST_LOAD_N;
			o_access_read   <= 1'b0;
			o_addr          <= {`DBSP_ADDR_W{1'b0}};
			gap_q           <= `DBSP_GAP_SAT;
			last_rd_q       <= 1'b0;
		end else if (acc_slot) begin
			if (accept) begin
				o_load_strobe_n <= 1'b0;
				o_access_read   <= ~i_req_write;
				o_addr          <= i_req_addr;
				gap_q           <= 3'h0;
				last_rd_q       <= ~i_req_write;
			end else begin
				// Strobe high makes the cycle idle; access type is left as is
				o_load_strobe_n <= 1'b1;
				if (gap_q != `DBSP_GAP_SAT)
					gap_q <= gap_q + 3'h1;
			end
		end
	end

	// Write words queue one slot per half cycle; slot 1 goes out at the second
	// mid-point after the load so word 0 is centred on the second positive rise after the load
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_dq               <= {`DBSP_WORD_W{1'b0}};
			o_dq_oe            <= 1'b0;
			o_byte_lane_mask_n <= `DBSP_RST_MASK_N;
			wq_v               <= {SLOTS{1'b0}};
			for (i = 0; i < SLOTS; i = i + 1) begin
				wq_dat[i] <= {`DBSP_WORD_W{1'b0}};
				wq_msk[i] <= `DBSP_RST_MASK_N;
			end
		end else if (mid_slot) begin
			o_dq               <= wq_dat[0];
			o_dq_oe            <= wq_v[0];
			o_byte_lane_mask_n <= wq_msk[0];
			for (i = 0; i < SLOTS - 1; i = i + 1) begin
				wq_dat[i] <= wq_dat[i+1];
				wq_msk[i] <= wq_msk[i+1];
				wq_v[i]   <= wq_v[i+1];
			end
			wq_dat[SLOTS-1] <= {`DBSP_WORD_W{1'b0}};
			wq_msk[SLOTS-1] <= `DBSP_RST_MASK_N;
			wq_v[SLOTS-1]   <= 1'b0;
			if (accept && i_req_write) begin
				for (i = 0; i < `DBSP_BURST; i = i + 1) begin
					wq_dat[i+1] <= i_wr_data[i*`DBSP_WORD_W +: `DBSP_WORD_W];
					wq_msk[i+1] <= ~i_wr_be[i*`DBSP_LANES +: `DBSP_LANES];
					wq_v[i+1]   <= 1'b1;
				end
			end
		end
	end

	// Read capture: a bit per future half cycle marks an expected word, so a
	// following read can be scheduled while the previous one still drains
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_sched_q <= 8'h00;
			rd_idx_q   <= 2'h0;
			o_rd_data  <= {`DBSP_BURST_W{1'b0}};
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			if (accept && !i_req_write)
				rd_sched_q <= rd_sched_q | (8'h0f << (lat + 3'h1));
			else if (cap_slot) begin
				rd_sched_q <= {1'b0, rd_sched_q[7:1]};
				if (rd_sched_q[0]) begin
					o_rd_data[rd_idx_q*`DBSP_WORD_W +: `DBSP_WORD_W] <= dq_sync;
					rd_idx_q <= rd_idx_q + 2'h1;
					if (rd_idx_q == 2'h3)
						o_rd_valid <= 1'b1;
				end
			end
		end
	end

endmodule // dbsp_ctrl

`default_nettype wire

// ===== dbsp_ctrl_props.sv
// Purpose: Port assertions for the DDR burst SRAM port controller
// Assumes: Single-clock strap; device clock is eight controller cycles
// Notes:   Load spacing is counted in controller cycles since the last load
`include "dbsp_defines.vh"
`default_nettype none
module dbsp_chk (
	input wire logic                    i_clk,              // Clock
	input wire logic                    i_nrst,             // Reset, active low
	input wire logic                    o_k,                // Device clock
	input wire logic                    o_c,                // Output clock
	input wire logic                    o_c_n,              // Negative output clock
	input wire logic                    o_load_strobe_n,    // Load strobe
	input wire logic                    o_access_read,      // Access type
	input wire logic                    o_dq_oe,            // Data drive enable
	input wire logic [`DBSP_LANES-1:0]  o_byte_lane_mask_n, // Byte-lane masks
	input wire logic                    o_rd_valid,         // Read burst done
	input wire logic                    o_pll_off_n         // PLL strap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] gap_q;
	logic       rd_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gap_q <= 6'h3f;
			rd_q  <= 1'b0;
		end else if ($fell(o_load_strobe_n)) begin
			gap_q <= 6'h00;
			rd_q  <= o_access_read;
		end else if (gap_q != 6'h3f) begin
			gap_q <= gap_q + 6'h01;
		end
	end
	strap_high_a: assert property (o_c && o_c_n)
		else $error("output clocks not held high");
	k_period_a: assert property ($rose(o_k) |-> o_k[*4] ##1 !o_k[*4] ##1 o_k)
		else $error("device clock period wrong");
	load_hold_a: assert property ($fell(o_load_strobe_n) |-> !o_load_strobe_n[*8] ##1 o_load_strobe_n)
		else $error("load strobe width wrong");
	load_edge_a: assert property ($fell(o_load_strobe_n) |-> !o_k ##[1:3] $rose(o_k))
		else $error("load not set up before clock rise");
	type_stable_a: assert property (!o_load_strobe_n && $past(!o_load_strobe_n) |-> $stable(o_access_read))
		else $error("access type moved during load");
	load_gap_a: assert property ($fell(o_load_strobe_n) |-> gap_q >= 6'h0f)
		else $error("loads closer than two device cycles");
	rd_wr_idle_a: assert property ($fell(o_load_strobe_n) && !o_access_read && rd_q |-> gap_q >= 6'h1f)
		else $error("write too soon after read");
	wr_data_a: assert property ($rose(o_dq_oe) |-> !o_access_read ##15 o_dq_oe)
		else $error("write data window wrong");
	mask_idle_a: assert property (!o_dq_oe |-> o_byte_lane_mask_n == 4'hf)
		else $error("mask active while idle");
	pll_lat_a: assert property ($fell(o_load_strobe_n) && o_access_read && o_pll_off_n |-> ##[29:31] o_rd_valid)
		else $error("read result late with pll on");
	dll_lat_a: assert property ($fell(o_load_strobe_n) && o_access_read && !o_pll_off_n |-> ##[25:27] o_rd_valid)
		else $error("read result late with pll off");
endmodule // dbsp_chk
bind dbsp_ctrl dbsp_chk chk (.i_clk, .i_nrst, .o_k, .o_c, .o_c_n, .o_load_strobe_n, .o_access_read,
	.o_dq_oe, .o_byte_lane_mask_n, .o_rd_valid, .o_pll_off_n);
`default_nettype wire

// ===== dbsp_sram.sv
// Purpose: Behavioural DDR burst-of-four SRAM in single-clock mode
// Assumes: No pull on the data pins
// Notes:   Idle pins toggle so a stale word never passes for data
`default_nettype none
module dbsp_sram (
	input  wire logic        i_k,      // Positive input clock
	input  wire logic        i_k_n,    // Negative input clock
	input  wire logic        i_load_n, // Load strobe, active low
	input  wire logic        i_rd,     // Access type, high read
	input  wire logic [20:0] i_a,      // Address
	input  wire logic [35:0] i_d,      // Write data
	input  wire logic [3:0]  i_bm_n,   // Byte-lane masks, active low
	input  wire logic        i_pll_n,  // PLL strap
	output var  logic [35:0] o_q       // Read data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [35:0] mem [int];
	int          rs [int];
	int          ws [int];
	int          h = 0;
	int          last = -9;
	initial o_q = 36'h0;
	always @(posedge i_k or posedge i_k_n) begin : half
		int i;
		h++;
		if (i_k && !i_load_n && h - last > 2) begin
			last = h;
			for (i = 0; i < 4; i++) begin
				if (i_rd) rs[h + (i_pll_n ? 3 : 2) + i] = {i_a[20:2], 2'(i_a[1:0] + i)};
				else ws[h + 2 + i] = {i_a[20:2], 2'(i_a[1:0] + i)};
			end
		end
		if (ws.exists(h)) begin
			if (!mem.exists(ws[h])) mem[ws[h]] = 36'h0;
			for (i = 0; i < 4; i++) if (!i_bm_n[i]) mem[ws[h]][9*i +: 9] = i_d[9*i +: 9];
			ws.delete(h);
		end
		if (rs.exists(h)) begin
			o_q <= mem.exists(rs[h]) ? mem[rs[h]] : 36'h0;
			rs.delete(h);
		end else o_q <= ~o_q;
	end
endmodule // dbsp_sram
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the DDR burst SRAM port controller
// Assumes: Device model on the pins; both PLL strap settings are run
// Notes:   Random reads and writes in a small window force hits and bypasses
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0, i_nrst = 1'b0, i_pll_on = 1'b1, i_req_valid = 1'b0, i_req_write = 1'b0;
	logic o_req_ready, o_rd_valid, o_k, o_k_n, o_c, o_c_n, o_load_strobe_n, o_rd, o_dq_oe, o_pll_off_n;
	logic [20:0]  i_req_addr = '0, o_addr;
	logic [143:0] i_wr_data = '0, o_rd_data;
	logic [15:0]  i_wr_be = '0;
	logic [35:0]  i_dq, o_dq, tm [int];
	logic [3:0]   o_bm_n;
	logic [143:0] exq [$];
	logic [31:0]  rs_q = 32'h45;
	int           fails = 0, n_compared = 0;
	dbsp_ctrl uut (.i_clk, .i_nrst, .i_pll_on, .i_req_valid, .i_req_write, .i_req_addr, .i_wr_data,
		.i_wr_be, .i_dq, .o_req_ready, .o_rd_valid, .o_rd_data, .o_k, .o_k_n, .o_c, .o_c_n,
		.o_load_strobe_n, .o_access_read(o_rd), .o_addr, .o_dq, .o_dq_oe,
		.o_byte_lane_mask_n(o_bm_n), .o_pll_off_n);
	dbsp_sram dev (.i_k(o_k), .i_k_n(o_k_n), .i_load_n(o_load_strobe_n), .i_rd(o_rd), .i_a(o_addr),
		.i_d(o_dq), .i_bm_n(o_bm_n), .i_pll_n(o_pll_off_n), .o_q(i_dq));
	function automatic logic [31:0] rnd();
		rs_q ^= rs_q << 13;
		rs_q ^= rs_q >> 17;
		rs_q ^= rs_q << 5;
		return rs_q;
	endfunction
	task automatic check(input logic [143:0] got, input logic [143:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Called just after an edge; valid stays up so back-to-back takes are legal
	task automatic req(input logic w, input logic [20:0] ad);
		int n;
		int k;
		int j;
		logic tk;
		logic [143:0] ex;
		i_req_valid <= 1'b1;
		i_req_write <= w;
		i_req_addr <= ad;
		i_wr_data <= 144'({rnd(), rnd(), rnd(), rnd(), rnd()});
		i_wr_be <= 16'(rnd());
		n = 0;
		do begin
			#98 tk = o_req_ready;
			@(posedge i_clk);
			#1 n++;
		end while (tk !== 1'b1 && n < 100);
		check(tk, 1'b1);
		for (k = 0; k < 4; k++) begin
			j = {ad[20:2], 2'(ad[1:0] + k)};
			if (!tm.exists(j)) tm[j] = '0;
			for (n = 0; n < 4; n++) if (w && i_wr_be[4*k+n]) tm[j][9*n +: 9] = i_wr_data[36*k+9*n +: 9];
			ex[36*k +: 36] = tm[j];
		end
		if (!w) exq.push_back(ex);
	endtask
	always @(negedge i_clk) begin
		if (o_rd_valid === 1'b1) check(o_rd_data, exq.size() ? exq.pop_front() : 'x);
	end
	initial forever #50 i_clk = ~i_clk;
	initial begin : wd
		#500000;
		fails++;
		final_report();
	end
	initial begin : main
		int p;
		int i;
		logic [20:0] base;
		base = 21'(rnd());
		for (p = 0; p < 2; p++) begin
			#1 i_nrst = 1'b0;
			i_pll_on = (p == 0);
			repeat (5) @(posedge i_clk);
			check(o_load_strobe_n, 1'b1);
			#1 i_nrst = 1'b1;
			for (i = 0; i < 24; i++) req(i < 4 || 1'(rnd()), {base[20:4], 4'(rnd())});
			i_req_valid <= 1'b0;
			repeat (60) @(posedge i_clk);
			check(o_pll_off_n, i_pll_on);
			check(exq.size(), 0);
		end
		final_report();
	end
endmodule // tb
`default_nettype wire
